// ---- design/remote_switch_bank_control.sv ----
// Remote switch bank controller: loop routing, remote footswitch, banks, MIDI filter and AXI4-Lite registers.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
module remote_switch_bank_control #(
    parameter int debounce_len = switch_bank_pkg::debounce_cycles,
    parameter int short_len = switch_bank_pkg::short_hold_cycles,
    parameter int long_len = switch_bank_pkg::long_hold_cycles,
    parameter int blink_len = switch_bank_pkg::blink_cycles
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] front_input_press,
    input wire logic [3:0] front_output_press,
    input wire logic front_mute_press,
    input wire logic [3:0] remote_foot_press,
    input wire logic remote_mute_level,
    input wire logic [7:0] config_switch,
    input wire logic midi_valid,
    input wire logic [7:0] midi_status,
    input wire logic [6:0] midi_data1,
    input wire logic [6:0] midi_data2,
    output logic [3:0] input_enable,
    output logic [3:0] output_enable,
    output logic [3:0] remote_foot_led,
    output logic loop_led,
    output logic front_mute_led,
    output logic remote_mute_led,
    output logic remote_status_led,
    output logic remote_pedal_loop_send,
    output logic [3:0] amp_via_local_effects,
    output logic [3:0] amp_via_remote_pedal_loop,
    output logic midi_accept
);
    import switch_bank_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic [3:0] amp_dry_reg, amp_dry_next;
    logic [3:0] inputs_reg, inputs_next;
    logic [3:0] outputs_reg, outputs_next;
    logic muted_reg, muted_next;
    logic [3:0] saved_out_reg, saved_out_next;
    mode_e mode_reg, mode_next;
    logic [1:0] bank_idx_reg, bank_idx_next;
    logic [3:0] pending_reg, pending_next;
    // Bank memory has no reset on purpose so it survives a reset like retained storage.
    logic [3:0] bank_mem [num_banks];
    logic bank_we;
    logic [31:0] deb_cnt_reg, deb_cnt_next;
    logic mute_stable_reg, mute_stable_next;
    logic [31:0] hold_cnt_reg, hold_cnt_next;
    logic short_fired_reg, short_fired_next;
    logic long_fired_reg, long_fired_next;
    logic [31:0] blink_cnt_reg, blink_cnt_next;
    logic [3:0] blink_phase_reg, blink_phase_next;
    logic awdone_reg, awdone_next, wdone_reg, wdone_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic short_press, long3_event, long8_event;
    logic amp_attach;
    logic [3:0] midi_chan;
    logic omni, cc_en, pc_en;

    // Merge byte lanes of a write into an old word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Mute footswitch debounce and hold timing
    // ----------------------------------------------------------------
    // Short press is reported on release only, so a long hold never also yields a short action.
    always_comb begin
        deb_cnt_next = deb_cnt_reg;
        mute_stable_next = mute_stable_reg;
        hold_cnt_next = hold_cnt_reg;
        short_fired_next = short_fired_reg;
        long_fired_next = long_fired_reg;
        short_press = 1'b0;
        long3_event = 1'b0;
        long8_event = 1'b0;
        if (remote_mute_level == mute_stable_reg) begin
            deb_cnt_next = '0;
        end else if (deb_cnt_reg >= 32'(debounce_len - 1)) begin
            deb_cnt_next = '0;
            mute_stable_next = remote_mute_level;
        end else begin
            deb_cnt_next = deb_cnt_reg + 32'd1;
        end
        if (mute_stable_reg) begin
            if (hold_cnt_reg != 32'hffff_ffff) begin
                hold_cnt_next = hold_cnt_reg + 32'd1;
            end
            // In run mode the 3 s event waits for release or the 8 s mark to decide; in other modes it fires at the 3 s mark.
            if (hold_cnt_reg == 32'(short_len - 1) && mode_reg != run_st) begin
                long3_event = 1'b1;
                short_fired_next = 1'b1;
            end
            if (hold_cnt_reg == 32'(long_len - 1) && mode_reg == run_st) begin
                long8_event = 1'b1;
                long_fired_next = 1'b1;
            end
        end else begin
            hold_cnt_next = '0;
            short_fired_next = 1'b0;
            long_fired_next = 1'b0;
            if (hold_cnt_reg != 32'd0 && !short_fired_reg && !long_fired_reg) begin
                if (hold_cnt_reg < 32'(short_len)) begin
                    short_press = 1'b1;
                end else if (mode_reg == run_st) begin
                    long3_event = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deb_cnt_reg <= '0;
            mute_stable_reg <= 1'b0;
            hold_cnt_reg <= '0;
            short_fired_reg <= 1'b0;
            long_fired_reg <= 1'b0;
        end else begin
            deb_cnt_reg <= deb_cnt_next;
            mute_stable_reg <= mute_stable_next;
            hold_cnt_reg <= hold_cnt_next;
            short_fired_reg <= short_fired_next;
            long_fired_reg <= long_fired_next;
        end
    end

    // ----------------------------------------------------------------
    // Switching, mute, banks and MIDI actions
    // ----------------------------------------------------------------
    assign amp_attach = ctrl_reg[ctrl_attach_amp_bit];
    assign midi_chan = {config_switch[0], config_switch[1], config_switch[2], config_switch[3]};
    assign omni = config_switch[4];
    assign cc_en = !(config_switch[5] && !config_switch[6]);
    assign pc_en = !(!config_switch[5] && config_switch[6]);
    assign midi_accept = midi_valid && (omni || midi_status[3:0] == midi_chan) &&
        ((midi_status[7:4] == midi_cc_status && cc_en) || (midi_status[7:4] == midi_pc_status && pc_en));

    // Bit order of config_switch: bit0 is switch 1 (wired so up reads 1, MSB channel bit is switch 1).
    always_comb begin
        logic [3:0] remote_sel;
        logic [3:0] target;
        logic [6:0] cc_idx;
        remote_sel = remote_foot_press;
        inputs_next = inputs_reg ^ front_input_press;
        outputs_next = outputs_reg ^ front_output_press;
        muted_next = muted_reg ^ front_mute_press;
        saved_out_next = saved_out_reg;
        mode_next = mode_reg;
        bank_idx_next = bank_idx_reg;
        pending_next = pending_reg;
        bank_we = 1'b0;
        target = amp_attach ? outputs_next : inputs_next;
        cc_idx = midi_data1 - cc_first_guitar;
        case (mode_reg)
            run_st: begin
                if (amp_attach) begin
                    outputs_next = outputs_next ^ remote_sel;
                    muted_next = muted_next ^ short_press;
                end else begin
                    inputs_next = inputs_next ^ remote_sel;
                    if (short_press) begin
                        if (!muted_reg) begin
                            saved_out_next = outputs_reg;
                            outputs_next = 4'h0;
                            muted_next = 1'b1;
                        end else begin
                            outputs_next = saved_out_reg;
                            muted_next = 1'b0;
                        end
                    end
                end
                if (long8_event) begin
                    mode_next = prog_st;
                    bank_idx_next = 2'd0;
                    pending_next = 4'h0;
                end else if (long3_event) begin
                    mode_next = bank_st;
                end
            end
            prog_st: begin
                pending_next = pending_reg ^ remote_sel;
                if (short_press) begin
                    bank_we = 1'b1;
                    bank_idx_next = bank_idx_reg + 2'd1;
                    pending_next = 4'h0;
                end else if (long3_event) begin
                    mode_next = run_st;
                end
            end
            default: begin
                for (int i = 0; i < num_banks; i++) begin
                    if (remote_sel[i]) begin
                        target = bank_mem[i];
                    end
                end
                if (amp_attach) begin
                    outputs_next = target;
                    muted_next = muted_next ^ short_press;
                end else begin
                    inputs_next = target;
                end
                if (long3_event) begin
                    mode_next = run_st;
                end
            end
        endcase
        // MIDI control changes act last so a message in the same cycle wins over a footswitch.
        if (midi_accept && midi_status[7:4] == midi_cc_status) begin
            if (midi_data1 >= cc_first_guitar && midi_data1 < cc_first_amp) begin
                inputs_next[cc_idx[1:0]] = midi_data2 >= cc_on_threshold;
            end else if (midi_data1 >= cc_first_amp && midi_data1 < cc_mute) begin
                outputs_next[cc_idx[1:0]] = midi_data2 >= cc_on_threshold;
            end else if (midi_data1 == cc_mute) begin
                muted_next = midi_data2 >= cc_on_threshold;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inputs_reg <= 4'h0;
            outputs_reg <= 4'h0;
            muted_reg <= 1'b0;
            saved_out_reg <= 4'h0;
            mode_reg <= run_st;
            bank_idx_reg <= 2'd0;
            pending_reg <= 4'h0;
        end else begin
            inputs_reg <= inputs_next;
            outputs_reg <= outputs_next;
            muted_reg <= muted_next;
            saved_out_reg <= saved_out_next;
            mode_reg <= mode_next;
            bank_idx_reg <= bank_idx_next;
            pending_reg <= pending_next;
        end
    end

    // Bank storage; initial zero contents are the unprogrammed default.
    initial begin
        for (int i = 0; i < num_banks; i++) begin
            bank_mem[i] = 4'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (bank_we) begin
            bank_mem[bank_idx_reg] <= pending_reg;
        end
    end

    // ----------------------------------------------------------------
    // Programming blink pattern
    // ----------------------------------------------------------------
    // Phases 0..2n-1 blink n times, then four dark phases separate the repeats.
    always_comb begin
        blink_cnt_next = blink_cnt_reg + 32'd1;
        blink_phase_next = blink_phase_reg;
        if (mode_reg != prog_st) begin
            blink_cnt_next = '0;
            blink_phase_next = 4'h0;
        end else if (blink_cnt_reg >= 32'(blink_len - 1)) begin
            blink_cnt_next = '0;
            blink_phase_next = (blink_phase_reg >= {bank_idx_reg, 1'b1} + 4'd4) ? 4'h0 : blink_phase_reg + 4'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_reg <= '0;
            blink_phase_reg <= 4'h0;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_phase_reg <= blink_phase_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs and routing
    // ----------------------------------------------------------------
    // Mute gates the outputs so the stored enables survive for the shared mute case.
    assign input_enable = inputs_reg;
    assign output_enable = muted_reg ? 4'h0 : outputs_reg;
    assign remote_foot_led = (mode_reg == prog_st) ? pending_reg : (amp_attach ? outputs_reg : inputs_reg);
    assign loop_led = ctrl_reg[ctrl_loop_on_bit];
    assign front_mute_led = muted_reg;
    assign remote_mute_led = (mode_reg == prog_st) ?
        (!blink_phase_reg[0] && blink_phase_reg < {1'b0, bank_idx_reg, 1'b0} + 4'd2) : muted_reg;
    assign remote_status_led = mode_reg == bank_st;
    assign remote_pedal_loop_send = ctrl_reg[ctrl_loop_on_bit] && inputs_reg != 4'h0;
    // The remote loop feeds both local sides equally, so wet amps see both loops.
    assign amp_via_local_effects = output_enable & ~amp_dry_reg;
    assign amp_via_remote_pedal_loop = ctrl_reg[ctrl_loop_on_bit] ? output_enable : 4'h0;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    always_comb begin
        logic aw_hs, w_hs;
        aw_hs = s_axi_awvalid && !awdone_reg;
        w_hs = s_axi_wvalid && !wdone_reg;
        awdone_next = awdone_reg || aw_hs;
        wdone_next = wdone_reg || w_hs;
        awaddr_next = aw_hs ? s_axi_awaddr : awaddr_reg;
        wdata_next = w_hs ? s_axi_wdata : wdata_reg;
        wstrb_next = w_hs ? s_axi_wstrb : wstrb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        amp_dry_next = amp_dry_reg;
        if (awdone_reg && wdone_reg && !bvalid_reg) begin
            awdone_next = 1'b0;
            wdone_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = 2'b00;
            if (awaddr_reg[7:2] == ctrl_off[7:2]) begin
                ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0003;
            end else if (awaddr_reg[7:2] == midi_off[7:2]) begin
                amp_dry_next = wstrb_reg[0] ? wdata_reg[3:0] : amp_dry_reg;
            end else if (awaddr_reg[7:2] != status_off[7:2] && awaddr_reg[7:2] != bank_off[7:2]) begin
                bresp_next = 2'b10;
            end
        end
        rvalid_next = rvalid_reg && !s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = 2'b00;
            if (s_axi_araddr[7:2] == ctrl_off[7:2]) begin
                rdata_next = ctrl_reg;
            end else if (s_axi_araddr[7:2] == status_off[7:2]) begin
                rdata_next = {18'h0, bank_idx_reg, 1'b0, mode_reg == prog_st, mode_reg == bank_st, muted_reg,
                              outputs_reg, inputs_reg};
            end else if (s_axi_araddr[7:2] == midi_off[7:2]) begin
                rdata_next = {20'h0, config_switch, amp_dry_reg};
            end else if (s_axi_araddr[7:2] == bank_off[7:2]) begin
                rdata_next = {16'h0, bank_mem[3], bank_mem[2], bank_mem[1], bank_mem[0]};
            end else begin
                rdata_next = 32'h0000_0000;
                rresp_next = 2'b10;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= ctrl_reset;
            amp_dry_reg <= 4'h0;
            awdone_reg <= 1'b0;
            wdone_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'b00;
        end else begin
            ctrl_reg <= ctrl_next;
            amp_dry_reg <= amp_dry_next;
            awdone_reg <= awdone_next;
            wdone_reg <= wdone_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_awready = !awdone_reg;
    assign s_axi_wready = !wdone_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule // remote_switch_bank_control

// ---- design/switch_bank_pkg.sv ----
// Package with register map, field positions, reset values and timing constants of the switch bank controller.
package switch_bank_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h04;
    localparam logic [7:0] midi_off = 8'h08;
    localparam logic [7:0] bank_off = 8'h0c;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ctrl_loop_on_bit = 0;
    localparam int ctrl_attach_amp_bit = 1;
    localparam int status_mute_bit = 8;
    localparam int status_bank_mode_bit = 9;
    localparam int status_prog_bit = 10;
    localparam int status_prog_bank_pos = 12;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int clk_hz = 10_000_000;
    localparam int debounce_ms = 10;
    localparam int debounce_cycles = clk_hz / 1000 * debounce_ms;
    localparam int short_hold_s = 3;
    localparam int long_hold_s = 8;
    localparam int short_hold_cycles = clk_hz * short_hold_s;
    localparam int long_hold_cycles = clk_hz * long_hold_s;
    localparam int blink_ms = 250;
    localparam int blink_cycles = clk_hz / 1000 * blink_ms;
    localparam int num_banks = 4;
    // ----------------------------------------------------------------
    // MIDI constants
    // ----------------------------------------------------------------
    localparam logic [3:0] midi_cc_status = 4'hb;
    localparam logic [3:0] midi_pc_status = 4'hc;
    localparam logic [6:0] cc_first_guitar = 7'h58;
    localparam logic [6:0] cc_first_amp = 7'h5c;
    localparam logic [6:0] cc_mute = 7'h60;
    localparam logic [6:0] cc_loop = 7'h61;
    localparam logic [6:0] cc_on_threshold = 7'h40;
    typedef enum logic [1:0] {run_st, prog_st, bank_st} mode_e;
endpackage : switch_bank_pkg

// ---- testbench/remote_ctl.sv ----
// Model of the remote footswitch unit and the MIDI controller.
`timescale 1ns/1ns
module remote_ctl (input wire logic aclk, a, output logic [3:0] f, output logic m, v,
    output logic [7:0] s, output logic [6:0] d1, d2);
    // Nothing pressed at start.
    initial {f, m, v, s, d1, d2} = '0;
    task automatic tap(input logic [3:0] k);
        @(posedge aclk) f <= k;
        @(posedge aclk) f <= 4'h0;
        @(posedge aclk);
    endtask
    // Mute held n cycles, then the release is given time to pass the debounce.
    task automatic hold(input int n);
        @(posedge aclk) m <= 1'b1;
        repeat (n) @(posedge aclk);
        m <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
    // After a message the lines show inverted leftovers, never the stale value.
    task automatic msg(input logic [7:0] st, output logic acc);
        @(posedge aclk) {v, s, d1, d2} <= {1'b1, st, 7'h58, 7'h40};
        @(negedge aclk) acc = a;
        @(posedge aclk) {v, s, d1, d2} <= {1'b0, ~st, 7'h27, 7'h3f};
    endtask
endmodule // remote_ctl

// ---- testbench/remote_switch_bank_control_sva.sv ----
// Port checker of the switch bank controller.
`timescale 1ns/1ns
module remote_switch_bank_control_sva import switch_bank_pkg::*; (
    input wire logic aclk, aresetn, midi_valid, loop_led, front_mute_led, remote_status_led, midi_accept,
    input wire logic remote_pedal_loop_send,
    input wire logic [3:0] front_input_press, remote_foot_press, input_enable, output_enable,
    input wire logic [3:0] amp_via_local_effects, amp_via_remote_pedal_loop,
    input wire logic [7:0] config_switch, midi_status
);
    // One clock domain; reset silences every check. Switch 1 is the top bit of the channel code.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire [3:0] code = {config_switch[0], config_switch[1], config_switch[2], config_switch[3]};
    chk_loop_send: assert property (remote_pedal_loop_send == (loop_led && |input_enable))
        else $error("loop send wrong");
    chk_remote_amps: assert property (amp_via_remote_pedal_loop == (loop_led ? output_enable : 4'h0))
        else $error("remote loop amps wrong");
    chk_local_amps: assert property ((amp_via_local_effects & ~output_enable) == 4'h0)
        else $error("effects amp not enabled");
    chk_mute_gate: assert property (front_mute_led && $past(front_mute_led) |-> output_enable == 4'h0)
        else $error("amp live while muted");
    chk_front_toggle: assert property (front_input_press == 4'h1 && remote_foot_press == 4'h0 && !midi_valid
        |=> input_enable[0] != $past(input_enable[0])) else $error("front switch ignored");
    chk_chan_filter: assert property (!config_switch[4] && midi_status[3:0] != code |-> !midi_accept)
        else $error("wrong channel accepted");
    chk_cc_only: assert property (config_switch[6:5] == 2'b10 && midi_status[7:4] == midi_pc_status
        |-> !midi_accept) else $error("program change accepted");
    chk_pc_only: assert property (config_switch[6:5] == 2'b01 && midi_status[7:4] == midi_cc_status
        |-> !midi_accept) else $error("control change accepted");
    // Main scenarios reached.
    cover property (midi_accept);
    cover property ($rose(remote_status_led));
    cover property (front_mute_led);
endmodule // remote_switch_bank_control_sva
bind remote_switch_bank_control remote_switch_bank_control_sva chk (.aclk(aclk), .aresetn(aresetn),
    .midi_valid(midi_valid), .loop_led(loop_led), .front_mute_led(front_mute_led),
    .remote_status_led(remote_status_led), .midi_accept(midi_accept),
    .remote_pedal_loop_send(remote_pedal_loop_send), .front_input_press(front_input_press),
    .remote_foot_press(remote_foot_press), .input_enable(input_enable), .output_enable(output_enable),
    .amp_via_local_effects(amp_via_local_effects), .amp_via_remote_pedal_loop(amp_via_remote_pedal_loop),
    .config_switch(config_switch), .midi_status(midi_status));

// ---- testbench/test_remote_switch_bank_control.sv ----
// Self-checking bench of the switch bank controller.
`timescale 1ns/1ns
`define CK(x, e) begin #1; comparisons++; if ((x) !== (e)) begin bad_count++; $display("unexpected %0t %h %h", $time, x, e); end end
module test_remote_switch_bank_control;
    import switch_bank_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, front_mute_press, remote_mute_level, acc;
    logic midi_valid, midi_accept, loop_led, front_mute_led, remote_mute_led, remote_status_led, remote_pedal_loop_send;
    logic [7:0] s_axi_awaddr, s_axi_araddr, config_switch, midi_status;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [3:0] s_axi_wstrb, front_input_press, front_output_press, remote_foot_press, input_enable, output_enable;
    logic [3:0] remote_foot_led, amp_via_local_effects, amp_via_remote_pedal_loop;
    logic [6:0] midi_data1, midi_data2;
    int bad_count = 0, comparisons = 0;
    remote_switch_bank_control #(.debounce_len(2), .short_len(30), .long_len(80), .blink_len(3)) DUT (.*);
    remote_ctl p (.aclk(aclk), .a(midi_accept), .f(remote_foot_press), .m(remote_mute_level), .v(midi_valid),
        .s(midi_status), .d1(midi_data1), .d2(midi_data2));
    // Free-running system clock.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic end_sim;
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One register access; ready is sampled before the edge, so each channel drops exactly where it is taken.
    task automatic ax(input bit we, input logic [7:0] ad, input logic [31:0] d);
        int n;
        bit pb, ta, tw, tb;
        @(posedge aclk) {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {ad, ad, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {we, we, we, !we, !we};
        pb = 1'b1;
        for (n = 0; pb && n < 99; n++) begin
            @(negedge aclk) ta = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);
            tw = s_axi_wvalid & s_axi_wready;
            tb = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
            {r, resp} = {s_axi_rdata, we ? s_axi_bresp : s_axi_rresp};
            @(posedge aclk) if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) {s_axi_bready, s_axi_rready} <= 2'b00;
            pb = !tb;
        end
        if (pb) begin
            bad_count++;
            end_sim;
        end
    endtask
    // Front panel pulses, packed as inputs, outputs, mute.
    task automatic pf(input logic [8:0] k);
        @(posedge aclk) {front_input_press, front_output_press, front_mute_press} <= k;
        @(posedge aclk) {front_input_press, front_output_press, front_mute_press} <= 9'h000;
        @(posedge aclk);
    endtask
    task automatic s_bank;
        p.hold(90);
        ax(0, status_off, 0);
        `CK(r[13:10], 4'h1)
        p.tap(4'h3);
        p.hold(5);
        p.hold(40);
        p.hold(40);
        `CK(remote_status_led, 1'b1)
        p.tap(4'h1);
        `CK({remote_foot_led, input_enable}, 8'h33)
        pf(9'h080);
        `CK(input_enable, 4'h7)
        p.tap(4'h2);
        `CK(input_enable, 4'h0)
        p.hold(40);
        `CK(remote_status_led, 1'b0)
    endtask
    task automatic s_loop;
        ax(1, ctrl_off, 32'h1);
        pf(9'h02a);
        `CK({loop_led, remote_pedal_loop_send, amp_via_remote_pedal_loop}, 6'h35)
        ax(1, midi_off, 32'h1);
        `CK(amp_via_local_effects, 4'h4)
        p.hold(5);
        `CK(output_enable, 4'h0)
        p.hold(5);
        `CK(output_enable, 4'h5)
    endtask
    task automatic s_amp;
        ax(1, ctrl_off, 32'h3);
        p.tap(4'h2);
        `CK(output_enable, 4'h7)
        pf(9'h001);
        `CK({front_mute_led, remote_mute_led, output_enable}, 6'h30)
        p.hold(5);
        `CK({front_mute_led, remote_mute_led, output_enable}, 6'h07)
        ax(0, 8'h10, 0);
        `CK({resp, r}, 34'h200000000)
    endtask
    // Each entry: switches, status byte, expected acceptance.
    task automatic s_midi;
        logic [23:0] t [8] = '{24'h70b301, 24'h20b000, 24'h20c001, 24'h40b001, 24'h40c000, 24'h41b801, 24'h41b100, 24'h48b101};
        foreach (t[k]) begin
            @(posedge aclk) config_switch <= t[k][23:16];
            p.msg(t[k][15:8], acc);
            `CK(acc, t[k][0])
        end
        `CK(input_enable, 4'h1)
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, front_mute_press} = '0;
        {front_input_press, front_output_press, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, config_switch} = 12'hf70;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        s_bank;
        s_loop;
        s_amp;
        s_midi;
        end_sim;
    end
endmodule // test_remote_switch_bank_control
